// ===== core/anr_latch_high.sv
/*
  anr_latch_high: a group of latched-high status bits.
  assumes: set is a per-bit event, clr is a one-cycle read of the register.
*/
`timescale 1ns/1ps
module anr_latch_high #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // events and clear
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  // latched bits
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] bits;
  } anr_lh_t;

  anr_lh_t st_r;
  anr_lh_t st_nxt;

  // ==========================================================================
  // an event in the clearing cycle stays latched
  always_comb begin
    st_nxt      = st_r;
    st_nxt.bits = set | (st_r.bits & ~{W{clr}});
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.bits;

endmodule

// ===== core/anr_pkg.sv
/*
  anr_pkg: register indices, field positions, reset values and enumerations
  for the auto-negotiation ability register bank.
  assumes: 16-bit management registers addressed by a 5-bit register index.
*/
package anr_pkg;

  // ==========================================================================
  // register indices on the management port
  localparam logic [4:0]  IDX_ADV      = 5'h04;
  localparam logic [4:0]  IDX_LP       = 5'h05;
  localparam logic [4:0]  IDX_EXP      = 5'h06;

  // ==========================================================================
  // advertisement register fields
  localparam int          ADV_RF_BIT   = 13;
  localparam int          ADV_PSYM_BIT = 10;
  localparam int          ADV_PASY_BIT = 11;
  localparam int          ADV_TXFD_BIT = 8;
  localparam int          ADV_TXHD_BIT = 7;
  localparam int          ADV_TFD_BIT  = 6;
  localparam int          ADV_THD_BIT  = 5;
  localparam logic [15:0] ADV_WR_MASK  = 16'h2dff;
  localparam logic [15:0] ADV_RST_VAL  = 16'h0081;

  // ==========================================================================
  // link partner ability register fields
  localparam int          LP_NP_BIT    = 15;
  localparam int          LP_ACK_BIT   = 14;
  localparam int          LP_PAUSE_BIT = 10;
  localparam logic [15:0] LP_CAP_MASK  = 16'ha7e0;
  localparam logic [15:0] LP_RST_VAL   = 16'h0001;

  // ==========================================================================
  // expansion register fields and the ieee 802.3 selector code
  localparam int          EXP_PDF_BIT  = 4;
  localparam int          EXP_LPNP_BIT = 3;
  localparam int          EXP_NP_BIT   = 2;
  localparam int          EXP_PR_BIT   = 1;
  localparam int          EXP_LPAN_BIT = 0;
  localparam logic        LOCAL_NP     = 1'b0;
  localparam logic [4:0]  SEL_8023     = 5'h01;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;

  // ==========================================================================
  // pause field codes
  localparam logic [1:0]  PAUSE_NONE   = 2'h0;
  localparam logic [1:0]  PAUSE_SYM    = 2'h1;
  localparam logic [1:0]  PAUSE_ASYM   = 2'h2;
  localparam logic [1:0]  PAUSE_BOTH   = 2'h3;

  // strap capture states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_LIVE = 2'b10
  } anr_strap_st_t;

endpackage

// ===== core/anr_regs.sv
/*
  anr_regs: auto-negotiation advertisement, link partner ability and
  expansion registers with pause resolution.
  assumes: the management port gives one-cycle read and write strobes with a
  5-bit register index; the negotiation engine gives received pages and
  events as one-cycle pulses in the ref_clk domain.
*/
// Behaviour
// - advertisement bits 11:10 hold a writable pause field, reset 00.
// - a both-pause advertisement resolves to at most one pause setting.
// - advertisement bit 13 is a writable remote fault flag, reset 0.
// - bit 7 writable reset 1; bits 8, 6, 5 reset from mode straps.
// - bits 4:0 hold selector 00001; writable locally, read-only for partner.
// - partner bit 15 is read-only next page, reset 0, unsupported locally.
// - partner bit 14 reads 1 once a link code word was received.
// - partner bit 10 reports partner pause support, read-only, reset 0.
// - partner bit 9 reports partner T4 ability, read-only, reset 0.
// - partner bits 13, 8, 7, 6, 5 are read-only abilities, reset 0.
// - expansion bit 4 latches high on a parallel detection fault.
// - expansion bit 3 reports partner next page ability, reset 0.
// - expansion bit 2 reads 0, no local next page ability.
// - expansion bit 1 latches high when a new page is received.
// - expansion bit 0 reports partner auto-negotiation ability, reset 0.
`timescale 1ns/1ps
module anr_regs (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // mode straps: 100tx full, 10t full, 10t half
  input  wire logic [2:0]  mode_strap,
  // management register port
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [4:0]  mgmt_idx,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  // negotiation engine events
  input  wire logic        page_rx,
  input  wire logic [15:0] page_word,
  input  wire logic        pd_fault,
  input  wire logic        lp_an_able,
  input  wire logic        an_done,
  input  wire logic        an_restart,
  // to the negotiation engine and mac
  output logic      [15:0] adv_word,
  output logic      [1:0]  pause_mode,
  output logic             pause_valid
);

  // ==========================================================================
  // state of the register bank
  typedef struct packed {
    logic [15:0] adv;
    logic [15:0] lp;
    logic        lpan;
    logic [15:0] rdata;
    logic        rvalid;
    logic [1:0]  pmode;
    logic        pvalid;
    logic        done_d;
  } anr_state_t;

  anr_state_t st_r;
  anr_state_t st_nxt;

  // captured straps and latched status
  logic [2:0]  strap_q;
  logic        strap_ld;
  logic [1:0]  lh_set;
  logic [1:0]  lh_q;
  logic        exp_rd;
  logic [15:0] exp_word;

  // ==========================================================================
  // pause resolution: never returns both settings at once
  function automatic logic [1:0] resolve_pause(input logic [1:0] local_p,
                                               input logic       lp_p);
    logic [1:0] res;
    res = anr_pkg::PAUSE_NONE;
    if (local_p[0] && lp_p) begin
      res = anr_pkg::PAUSE_SYM;
    end else if (local_p[1]) begin
      res = anr_pkg::PAUSE_ASYM;
    end
    return res;
  endfunction

  // read-only word of the partner register from a received page
  function automatic logic [15:0] lp_from_page(input logic [15:0] pw);
    logic [15:0] w;
    w = (pw & anr_pkg::LP_CAP_MASK) | anr_pkg::LP_RST_VAL;
    w[anr_pkg::LP_ACK_BIT] = 1'b1;
    return w;
  endfunction

  // ==========================================================================
  // strap capture after reset release
  anr_strap_capture #(
    .W (3)
  ) u_strap (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .strap_in (mode_strap),
    .strap_q  (strap_q),
    .strap_ld (strap_ld)
  );

  // ==========================================================================
  // latched-high expansion bits: index 1 fault, index 0 page received
  assign exp_rd = mgmt_rd && (mgmt_idx == anr_pkg::IDX_EXP);
  assign lh_set = {pd_fault, page_rx};

  anr_latch_high #(
    .W (2)
  ) u_lh (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .set     (lh_set),
    .clr     (exp_rd),
    .q       (lh_q)
  );

  // ==========================================================================
  // expansion word as seen by a read
  always_comb begin
    exp_word                         = anr_pkg::ZERO_WORD;
    exp_word[anr_pkg::EXP_PDF_BIT]   = lh_q[1];
    exp_word[anr_pkg::EXP_LPNP_BIT]  = st_r.lp[anr_pkg::LP_NP_BIT];
    exp_word[anr_pkg::EXP_NP_BIT]    = anr_pkg::LOCAL_NP;
    exp_word[anr_pkg::EXP_PR_BIT]    = lh_q[0];
    exp_word[anr_pkg::EXP_LPAN_BIT]  = st_r.lpan;
  end

  // ==========================================================================
  // next state of the bank
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.done_d = an_done;

    // strap load sets the duplex and 10t abilities once after reset
    if (strap_ld) begin
      st_nxt.adv[anr_pkg::ADV_TXFD_BIT] = strap_q[2];
      st_nxt.adv[anr_pkg::ADV_TFD_BIT]  = strap_q[1];
      st_nxt.adv[anr_pkg::ADV_THD_BIT]  = strap_q[0];
    end

    // host write: only the writable advertisement bits change
    if (mgmt_wr && (mgmt_idx == anr_pkg::IDX_ADV)) begin
      st_nxt.adv = (mgmt_wdata & anr_pkg::ADV_WR_MASK) |
                   (st_r.adv & ~anr_pkg::ADV_WR_MASK);
    end

    // restart forgets the partner, a page in the same cycle wins
    if (an_restart) begin
      st_nxt.lp     = anr_pkg::LP_RST_VAL;
      st_nxt.lpan   = 1'b0;
      st_nxt.pvalid = 1'b0;
      st_nxt.pmode  = anr_pkg::PAUSE_NONE;
    end
    if (page_rx) begin
      st_nxt.lp = lp_from_page(page_word);
    end

    // partner ability set by the engine or any received page, held until restart
    if (page_rx || lp_an_able) begin
      st_nxt.lpan = 1'b1;
    end else if (an_restart) begin
      st_nxt.lpan = 1'b0;
    end

    // resolve pause when negotiation completes
    if (an_done && !st_r.done_d) begin
      st_nxt.pmode  = resolve_pause({st_r.adv[anr_pkg::ADV_PASY_BIT],
                                     st_r.adv[anr_pkg::ADV_PSYM_BIT]},
                                    st_r.lp[anr_pkg::LP_PAUSE_BIT]);
      st_nxt.pvalid = 1'b1;
    end else if (!an_done) begin
      st_nxt.pvalid = 1'b0;
    end

    // read answer one cycle after the strobe, unmapped indices read zero
    if (mgmt_rd) begin
      st_nxt.rvalid = 1'b1;
      unique case (mgmt_idx)
        anr_pkg::IDX_ADV: begin
          st_nxt.rdata = st_r.adv;
        end
        anr_pkg::IDX_LP: begin
          st_nxt.rdata = st_r.lp;
        end
        anr_pkg::IDX_EXP: begin
          st_nxt.rdata = exp_word;
        end
        default: begin
          st_nxt.rdata = anr_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.adv    <= anr_pkg::ADV_RST_VAL;
      st_r.lp     <= anr_pkg::LP_RST_VAL;
      st_r.lpan   <= 1'b0;
      st_r.rdata  <= anr_pkg::ZERO_WORD;
      st_r.rvalid <= 1'b0;
      st_r.pmode  <= anr_pkg::PAUSE_NONE;
      st_r.pvalid <= 1'b0;
      st_r.done_d <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs straight from the state register
  assign mgmt_rdata  = st_r.rdata;
  assign mgmt_rvalid = st_r.rvalid;
  assign adv_word    = st_r.adv;
  assign pause_mode  = st_r.pmode;
  assign pause_valid = st_r.pvalid;

endmodule

// ===== core/anr_strap_capture.sv
/*
  anr_strap_capture: samples configuration straps at the first edge after reset.
  assumes: strap levels are stable around the release of reset_n.
*/
`timescale 1ns/1ps
module anr_strap_capture #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // strap pins
  input  wire logic [W-1:0] strap_in,
  // captured straps and load pulse
  output logic      [W-1:0] strap_q,
  output logic              strap_ld
);

  typedef struct packed {
    anr_pkg::anr_strap_st_t st;
    logic [W-1:0]           q;
    logic                   ld;
  } anr_sc_t;

  anr_sc_t st_r;
  anr_sc_t st_nxt;

  // ==========================================================================
  // capture once after release, then stay live
  always_comb begin
    st_nxt    = st_r;
    st_nxt.ld = 1'b0;
    unique case (st_r.st)
      anr_pkg::ST_HOLD: begin
        st_nxt.q  = strap_in;
        st_nxt.ld = 1'b1;
        st_nxt.st = anr_pkg::ST_LIVE;
      end
      anr_pkg::ST_LIVE: begin
        st_nxt.st = anr_pkg::ST_LIVE;
      end
      default: begin
        st_nxt.st = anr_pkg::ST_HOLD;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{st: anr_pkg::ST_HOLD, q: '0, ld: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign strap_q  = st_r.q;
  assign strap_ld = st_r.ld;

endmodule

// ===== verif/anr_engine_model.sv
/*
  anr_engine_model: negotiation engine facing the link partner.
  assumes: go is a one-cycle request from the bench.
*/
`timescale 1ns/1ps
module anr_engine_model (
  // clock
  input  wire logic        ref_clk,
  // request from the bench
  input  wire logic        go,
  input  wire logic [15:0] word,
  // engine events
  output logic             page_rx   = 1'b0,
  output logic      [15:0] page_word = 16'h0000,
  output logic             an_done   = 1'b0
);
  // one page pulse, word scrambled afterwards, completion three cycles on
  always @(posedge ref_clk) begin
    if (go) begin
      an_done   <= 1'b0;
      page_rx   <= 1'b1;
      page_word <= word;
      @(posedge ref_clk);
      page_rx   <= 1'b0;
      page_word <= ~word;
      repeat (2) @(posedge ref_clk);
      an_done   <= 1'b1;
    end
  end
endmodule

// ===== verif/anr_regs_asserts.sv
/*
  anr_regs_asserts: port timing checks for the register bank.
  assumes: bound into anr_regs, straps loaded before the first write.
*/
`timescale 1ns/1ps
module anr_regs_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // management port
  input wire logic        mgmt_rd,
  input wire logic        mgmt_wr,
  input wire logic [4:0]  mgmt_idx,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  // engine side
  input wire logic        pd_fault,
  input wire logic        an_done,
  input wire logic [15:0] adv_word,
  input wire logic [1:0]  pause_mode,
  input wire logic        pause_valid
);
  // ======
  // access decodes
  wire rd_exp = mgmt_rd && mgmt_idx == anr_pkg::IDX_EXP;
  wire wr_adv = mgmt_wr && mgmt_idx == anr_pkg::IDX_ADV;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // ======
  // pause result
  AST_PAUSE_LEGAL: assert property (pause_valid |-> pause_mode != anr_pkg::PAUSE_BOTH)
    else $error("pause result holds both modes");
  AST_PAUSE_ON: assert property ($rose(an_done) |=> pause_valid)
    else $error("no pause result after completion");
  AST_PAUSE_OFF: assert property (!an_done |=> !pause_valid)
    else $error("pause result without completion");

  // ======
  // advertisement and expansion
  AST_ADV_WRITE: assert property (wr_adv |=> adv_word == ($past(mgmt_wdata) & anr_pkg::ADV_WR_MASK))
    else $error("advertisement write lost");
  AST_ADV_FIXED: assert property ((adv_word & ~anr_pkg::ADV_WR_MASK) == 16'h0000)
    else $error("reserved advertisement bit set");
  AST_EXP_FIXED: assert property (rd_exp |=> mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[2])
    else $error("expansion fixed bits wrong");
  AST_PDF_SET: assert property (pd_fault ##1 !rd_exp ##1 rd_exp |=> mgmt_rdata[4])
    else $error("fault flag not latched");
  AST_PDF_CLR: assert property ((rd_exp && !pd_fault) ##1 !pd_fault ##1 rd_exp |=> !mgmt_rdata[4])
    else $error("fault flag not cleared by read");

  // main scenarios reached
  cover property (pause_valid && pause_mode == anr_pkg::PAUSE_SYM);
  cover property (pause_valid && pause_mode == anr_pkg::PAUSE_ASYM);
  cover property (rd_exp ##1 mgmt_rdata[4]);
endmodule

bind anr_regs anr_regs_asserts anr_regs_asserts_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
  .mgmt_idx(mgmt_idx), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .pd_fault(pd_fault), .an_done(an_done), .adv_word(adv_word),
  .pause_mode(pause_mode), .pause_valid(pause_valid)
);

// ===== verif/test_autoneg_ability_registers.sv
/*
  test_autoneg_ability_registers: register bank bench.
  assumes: design, engine model and checker compiled before this file.
*/
`timescale 1ns/1ps
module test_autoneg_ability_registers;
  // ======
  // bench signals
  logic        ref_clk    = 1'b0;
  logic        reset_n    = 1'b0;
  logic        mgmt_rd    = 1'b0;
  logic        mgmt_wr    = 1'b0;
  logic [4:0]  mgmt_idx   = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic        pd_fault   = 1'b0;
  logic [2:0]  mode_strap = 3'h5;
  logic [15:0] adv_word;
  logic        lp_an_able = 1'b0;
  logic        an_restart = 1'b0;
  logic        go         = 1'b0;
  logic [15:0] word       = 16'h0000;
  logic [15:0] mgmt_rdata;
  logic [15:0] page_word;
  logic [1:0]  pause_mode;
  logic        mgmt_rvalid;
  logic        page_rx;
  logic        an_done;
  logic        pause_valid;
  int          n_fail     = 0;
  int          num_checks = 0;

  // straps: 100tx full and 10t half first, 10t full only after the second reset
  anr_regs anr_regs_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .mode_strap(mode_strap),
    .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_idx(mgmt_idx),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .page_rx(page_rx), .page_word(page_word), .pd_fault(pd_fault),
    .lp_an_able(lp_an_able), .an_done(an_done), .an_restart(an_restart),
    .adv_word(adv_word), .pause_mode(pause_mode), .pause_valid(pause_valid)
  );
  anr_engine_model anr_engine_model_inst (
    .ref_clk(ref_clk), .go(go), .word(word),
    .page_rx(page_rx), .page_word(page_word), .an_done(an_done)
  );

  // 100 ns clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ======
  // compare, register access and page tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    @(posedge ref_clk) #1 mgmt_rd = 1'b1;
    mgmt_idx = i;
    @(posedge ref_clk) #1 mgmt_rd = 1'b0;
    chk({15'h0000, mgmt_rvalid}, 16'h0001);
    chk(mgmt_rdata, e);
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge ref_clk) #1 mgmt_wr = 1'b1;
    mgmt_idx   = i;
    mgmt_wdata = d;
    @(posedge ref_clk) #1 mgmt_wr = 1'b0;
  endtask

  task automatic pg(input logic [15:0] w);
    @(posedge ref_clk) #1 go = 1'b1;
    word = w;
    @(posedge ref_clk) #1 go = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ======
  // test sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(anr_pkg::IDX_ADV, 16'h01a1);
    rd(anr_pkg::IDX_LP, 16'h0001);
    rd(anr_pkg::IDX_EXP, 16'h0000);
    wr(anr_pkg::IDX_ADV, 16'hffff);
    rd(anr_pkg::IDX_ADV, 16'h2dff);
    wr(anr_pkg::IDX_ADV, 16'h0000);
    rd(anr_pkg::IDX_ADV, 16'h0000);
    wr(anr_pkg::IDX_ADV, 16'h0c01);
    chk(adv_word, 16'h0c01);
    pg(16'hffff);
    rd(anr_pkg::IDX_LP, 16'he7e1);
    rd(anr_pkg::IDX_EXP, 16'h000b);
    rd(anr_pkg::IDX_EXP, 16'h0009);
    chk({13'h0000, pause_valid, pause_mode}, 16'h0005);
    @(posedge ref_clk) #1 an_restart = 1'b1;
    @(posedge ref_clk) #1 an_restart = 1'b0;
    pd_fault = 1'b1;
    @(posedge ref_clk) #1 pd_fault = 1'b0;
    rd(anr_pkg::IDX_EXP, 16'h0010);
    rd(anr_pkg::IDX_LP, 16'h0001);
    lp_an_able = 1'b1;
    rd(anr_pkg::IDX_EXP, 16'h0001);
    lp_an_able = 1'b0;
    // fault held through a clearing read: the set wins, the next read still sees it
    pd_fault = 1'b1;
    rd(anr_pkg::IDX_EXP, 16'h0011);
    pd_fault = 1'b0;
    rd(anr_pkg::IDX_EXP, 16'h0011);
    rd(anr_pkg::IDX_EXP, 16'h0001);
    wr(anr_pkg::IDX_ADV, 16'h0801);
    pg(16'h0400);
    rd(anr_pkg::IDX_LP, 16'h4401);
    chk({13'h0000, pause_valid, pause_mode}, 16'h0006);
    wr(anr_pkg::IDX_ADV, 16'h0001);
    pg(16'h0000);
    chk({13'h0000, pause_valid, pause_mode}, 16'h0004);
    wr(anr_pkg::IDX_LP, 16'hffff);
    rd(anr_pkg::IDX_LP, 16'h4001);
    rd(5'h1f, 16'h0000);
    // second reset with other straps: only 10t full duplex
    mode_strap = 3'h2;
    @(posedge ref_clk) #1 reset_n = 1'b0;
    @(posedge ref_clk) #1 reset_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(anr_pkg::IDX_ADV, 16'h00c1);
    rd(anr_pkg::IDX_LP, 16'h0001);
    rd(anr_pkg::IDX_EXP, 16'h0000);
    end_sim();
  end

  // watchdog: the sequence needs about 90 cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
